// ==== ctu_pkg.sv ====
// Shared constants, register map and types for the control transfer unit.
package ctu_pkg;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] A_CTRL = 8'h00;  // Command word, a write while idle launches it.
  localparam logic [7:0] A_STAT = 8'h04;  // Busy, error and gate status.
  localparam logic [7:0] A_OPA  = 8'h08;  // First test operand.
  localparam logic [7:0] A_OPB  = 8'h0c;  // Second operand or target offset.
  localparam logic [7:0] A_SEL  = 8'h10;  // Far target selector.
  localparam logic [7:0] A_IMM  = 8'h14;  // Return release count in bytes.
  localparam logic [7:0] A_IPL  = 8'h18;  // Instruction pointer, low word.
  localparam logic [7:0] A_IPH  = 8'h1c;  // Instruction pointer, high word.
  localparam logic [7:0] A_SP   = 8'h20;  // Stack pointer.
  localparam logic [7:0] A_FLG  = 8'h24;  // Flags word.
  localparam logic [7:0] A_CS   = 8'h28;  // Code segment selector.
  localparam logic [7:0] A_RES  = 8'h2c;  // Byte written by a byte set.
  // Bus responses.
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // Flag bit positions inside the flags word.
  localparam int FLG_C = 0;
  localparam int FLG_P = 2;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 7;
  localparam int FLG_O = 11;
  // Condition code that tests the overflow flag alone.
  localparam logic [3:0] CC_OVERFLOW = 4'h0;
  // Reset values.
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [63:0] IP_RST    = 64'h0;
  localparam logic [31:0] SP_RST    = 32'h0000_0000;
  localparam logic [15:0] CS_RST    = 16'h0000;
  // Stack slot sizes and byte set values.
  localparam logic [31:0] STEP32    = 32'h0000_0004;
  localparam logic [31:0] STEP64    = 32'h0000_0008;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  // Operations that a command can start.
  typedef enum logic [2:0] {
    cond_byte_set_op = 3'b000, bit_test_op     = 3'b001,
    uncond_jump_op   = 3'b010, proc_call_op    = 3'b011,
    proc_return_op   = 3'b100, intr_return_op  = 3'b101,
    intr_service_op  = 3'b110, cond_branch_op  = 3'b111
  } op_e;
  // Ways a transfer target is given.
  typedef enum logic [2:0] {
    tgt_rel  = 3'b000, tgt_reg   = 3'b001, tgt_near = 3'b010,
    tgt_far  = 3'b011, tgt_cgate = 3'b100, tgt_tgate = 3'b101,
    tgt_tss  = 3'b110, tgt_rsv   = 3'b111
  } tgt_e;
  // Command word layout.
  typedef struct packed {
    logic [19:0] pad;
    logic        prot;
    logic        mode64;
    logic [3:0]  cond;
    tgt_e        kind;
    op_e         op;
  } ctrl_s;
  // Sequencer states.
  typedef enum logic [1:0] {
    st_idle = 2'b00, st_push = 2'b01, st_pop = 2'b10
  } state_e;
endpackage

// ==== control_transfer_unit.sv ====
// Control transfer execution unit with an AXI4-Lite register slave.
`timescale 1ns/100ps
module control_transfer_unit
  import ctu_pkg::*;
#(
  parameter int SD = 4  // Log2 of stack slots held.
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data.
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address and data.
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  logic [63:0] stack_mem [2**SD];   // Stack storage slots.
  state_e      state;               // Sequencer state.
  logic        phase;               // Second stack step pending.
  logic        two;                 // Operation takes two stack steps.
  ctrl_s       ctrl_q;              // Last accepted command.
  ctrl_s       cn;                  // Command word as being written.
  logic [63:0] instr_pointer;       // Instruction pointer.
  logic [31:0] stack_pointer_reg;   // Stack pointer.
  logic [31:0] proc_flags_word;     // Flags word.
  logic [15:0] code_seg;            // Code segment selector.
  logic [31:0] opa, opb, imm;       // Operand registers.
  logic [15:0] sel;                 // Far selector operand.
  logic [7:0]  result;              // Byte set destination.
  logic        err, gate;           // Status of the last command.
  logic [63:0] pend_ip, push_a, push_b; // Held target and stack data.
  logic [15:0] pend_cs;             // Held target segment.
  logic        aw_got, w_got;       // Write halves captured.
  logic [7:0]  wa;                  // Captured write address.
  logic [31:0] wd;                  // Captured write data.
  logic [3:0]  ws;                  // Captured byte enables.
  logic        wr_fire, launch;     // Write applied, command started.
  logic        wr_hit, rd_hit;      // Address decodes to a register.
  logic [31:0] rd_word, wmerge;     // Read mux, merged write word.
  logic        cond_hit;            // Condition code is met.
  logic [31:0] test_res;            // Intermediate AND value.
  logic [63:0] disp, tgt_ip, rel_ip; // Target computation.
  logic [15:0] tgt_cs;              // Target segment.
  logic        bad_tgt;             // Target kind not allowed.
  logic [31:0] step;                // Stack slot size in bytes.
  logic [63:0] pop_word;            // Word at the top of the stack.

  // Pick the stack slot for a byte address.
  function automatic logic [SD-1:0] slot(input logic [31:0] a, input logic m);
    slot = m ? a[SD+2:3] : a[SD+1:2];
  endfunction

  // Keep only the low word outside wide mode.
  function automatic logic [63:0] fit(input logic [63:0] v, input logic m);
    fit = m ? v : {32'h0, v[31:0]};
  endfunction

  assign wr_fire  = aw_got && w_got && !bvalid;
  assign launch   = wr_fire && wa == A_CTRL && state == st_idle;
  assign step     = ctrl_q.mode64 ? STEP64 : STEP32;
  assign pop_word = stack_mem[slot(stack_pointer_reg, ctrl_q.mode64)];

  // Merge the written bytes over the old value of the addressed register.
  always_comb begin
    wmerge = rd_word;
    for (int i = 0; i < 4; i++) begin
      if (ws[i]) begin
        wmerge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  end

  // Evaluate the condition code and the targets for the incoming command.
  always_comb begin
    logic base;
    base = 1'b0;
    cn = ctrl_s'(wmerge);
    case (cn.cond[3:1])
      3'h0: base = proc_flags_word[FLG_O];
      3'h1: base = proc_flags_word[FLG_C];
      3'h2: base = proc_flags_word[FLG_Z];
      3'h3: base = proc_flags_word[FLG_C] | proc_flags_word[FLG_Z];
      3'h4: base = proc_flags_word[FLG_S];
      3'h5: base = proc_flags_word[FLG_P];
      3'h6: base = proc_flags_word[FLG_S] ^ proc_flags_word[FLG_O];
      default: base = (proc_flags_word[FLG_S] ^ proc_flags_word[FLG_O])
                      | proc_flags_word[FLG_Z];
    endcase
    cond_hit = base ^ cn.cond[0];
    test_res = opa & opb;
    disp     = {{32{opb[31]}}, opb};
    rel_ip   = fit(instr_pointer + disp, cn.mode64);
    tgt_cs   = code_seg;
    bad_tgt  = 1'b0;
    // Jump and call share this target decode.
    case (cn.kind)
      tgt_rel: tgt_ip = rel_ip;
      tgt_reg, tgt_near: tgt_ip = fit({32'h0, opb}, cn.mode64);
      tgt_far: begin
        tgt_ip = {32'h0, opb};
        tgt_cs = sel;
      end
      default: begin
        tgt_ip  = {32'h0, opb};
        tgt_cs  = sel;
        bad_tgt = !cn.prot || cn.op != uncond_jump_op || cn.kind == tgt_rsv;
      end
    endcase
  end

  // Operand registers, writable at any time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opa <= 32'h0;
      opb <= 32'h0;
      imm <= 32'h0;
      sel <= 16'h0;
    end else if (wr_fire) begin
      if (wa == A_OPA) begin
        opa <= wmerge;
      end else if (wa == A_OPB) begin
        opb <= wmerge;
      end else if (wa == A_IMM) begin
        imm <= wmerge;
      end else if (wa == A_SEL) begin
        sel <= wmerge[15:0];
      end
    end
  end

  // Processor state and the command sequencer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= st_idle;
      phase             <= 1'b0;
      two               <= 1'b0;
      ctrl_q            <= ctrl_s'(CTRL_RST);
      instr_pointer     <= IP_RST;
      stack_pointer_reg <= SP_RST;
      proc_flags_word   <= FLAGS_RST;
      code_seg          <= CS_RST;
      result            <= BYTE_ZERO;
      err               <= 1'b0;
      gate              <= 1'b0;
      pend_ip           <= 64'h0;
      pend_cs           <= 16'h0;
      push_a            <= 64'h0;
      push_b            <= 64'h0;
    end else begin
      case (state)
        st_idle: begin
          if (launch) begin
            ctrl_q <= cn;
            err    <= 1'b0;
            gate   <= 1'b0;
            pend_ip <= tgt_ip;
            pend_cs <= tgt_cs;
            push_a <= instr_pointer;
            two    <= 1'b0;
            case (cn.op)
              cond_byte_set_op: result <= cond_hit ? BYTE_ONE : BYTE_ZERO;
              bit_test_op: begin
                // The AND value goes only to the flags, never to an operand.
                proc_flags_word[FLG_S] <= test_res[31];
                proc_flags_word[FLG_Z] <= test_res == 32'h0;
                proc_flags_word[FLG_P] <= ~^test_res[7:0];
              end
              cond_branch_op: begin
                if (cond_hit) begin
                  instr_pointer <= rel_ip;
                end
              end
              uncond_jump_op: begin
                if (bad_tgt) begin
                  err <= 1'b1;
                end else begin
                  instr_pointer <= tgt_ip;
                  code_seg      <= tgt_cs;
                  gate          <= cn.kind[2];
                end
              end
              proc_call_op, intr_service_op: begin
                if (bad_tgt) begin
                  err <= 1'b1;
                end else begin
                  state <= st_push;
                  if (cn.op == intr_service_op) begin
                    two    <= 1'b1;
                    push_a <= {32'h0, proc_flags_word};
                    push_b <= instr_pointer;
                  end
                end
              end
              default: begin
                state <= st_pop;
                two   <= cn.op == intr_return_op;
              end
            endcase
          end else if (wr_fire) begin
            if (wa == A_IPL) begin
              instr_pointer[31:0] <= wmerge;
            end else if (wa == A_IPH) begin
              instr_pointer[63:32] <= wmerge;
            end else if (wa == A_SP) begin
              stack_pointer_reg <= wmerge;
            end else if (wa == A_FLG) begin
              proc_flags_word <= wmerge;
            end else if (wa == A_CS) begin
              code_seg <= wmerge[15:0];
            end
          end
        end
        st_push: begin
          stack_pointer_reg <= stack_pointer_reg - step;
          if (two && !phase) begin
            phase <= 1'b1;
          end else begin
            phase         <= 1'b0;
            instr_pointer <= pend_ip;
            code_seg      <= pend_cs;
            state         <= st_idle;
          end
        end
        default: begin
          if (!phase) begin
            instr_pointer <= fit(pop_word, ctrl_q.mode64);
            if (two) begin
              stack_pointer_reg <= stack_pointer_reg + step;
              phase <= 1'b1;
            end else begin
              stack_pointer_reg <= stack_pointer_reg + step + imm;
              state <= st_idle;
            end
          end else begin
            proc_flags_word   <= pop_word[31:0];
            stack_pointer_reg <= stack_pointer_reg + step;
            phase <= 1'b0;
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // Stack store: data lands below the old pointer.
  always_ff @(posedge aclk) begin
    if (state == st_push) begin
      stack_mem[slot(stack_pointer_reg - step, ctrl_q.mode64)] <= phase ? push_b : push_a;
    end
  end

  // Register read mux and address decode.
  always_comb begin
    logic [7:0] a;
    a = wr_fire ? wa : araddr;
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    if (a == A_CTRL) begin
      rd_word = ctrl_q;
    end else if (a == A_STAT) begin
      rd_word = {29'h0, gate, err, state != st_idle};
    end else if (a == A_OPA) begin
      rd_word = opa;
    end else if (a == A_OPB) begin
      rd_word = opb;
    end else if (a == A_SEL) begin
      rd_word = {16'h0, sel};
    end else if (a == A_IMM) begin
      rd_word = imm;
    end else if (a == A_IPL) begin
      rd_word = instr_pointer[31:0];
    end else if (a == A_IPH) begin
      rd_word = instr_pointer[63:32];
    end else if (a == A_SP) begin
      rd_word = stack_pointer_reg;
    end else if (a == A_FLG) begin
      rd_word = proc_flags_word;
    end else if (a == A_CS) begin
      rd_word = {16'h0, code_seg};
    end else if (a == A_RES) begin
      rd_word = {24'h0, result};
    end else begin
      rd_hit = 1'b0;
    end
    wr_hit = rd_hit;
  end

  // Write channel handshakes and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      wa      <= 8'h0;
      wd      <= 32'h0;
      ws      <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
    end else begin
      if (awready && awvalid) begin
        awready <= 1'b0;
        aw_got  <= 1'b1;
        wa      <= awaddr;
      end else if (bvalid && bready) begin
        aw_got  <= 1'b0;
        awready <= 1'b1;
      end else if (!aw_got) begin
        awready <= 1'b1;
      end
      if (wready && wvalid) begin
        wready <= 1'b0;
        w_got  <= 1'b1;
        wd     <= wdata;
        ws     <= wstrb;
      end else if (bvalid && bready) begin
        w_got  <= 1'b0;
        wready <= 1'b1;
      end else if (!w_got) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OK;
    end else if (arready && arvalid) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_call_go;
    launch && cn.op == proc_call_op && !bad_tgt;
  endsequence
  sequence s_ret_go;
    launch && cn.op == proc_return_op;
  endsequence

  a_set_byte_val: assert property (launch && cn.op == cond_byte_set_op |=>
    result == {7'h0, $past(cond_hit)}) else $error("byte set value wrong");
  a_set_overflow: assert property (launch && cn.op == cond_byte_set_op
    && cn.cond == CC_OVERFLOW |=> result[0] == $past(proc_flags_word[FLG_O]))
    else $error("overflow byte set wrong");
  a_test_flags: assert property (launch && cn.op == bit_test_op |=>
    proc_flags_word[FLG_Z] == ($past(opa & opb) == 32'h0))
    else $error("test zero flag wrong");
  a_test_keeps: assert property (launch && cn.op == bit_test_op |=>
    $stable(opa) && $stable(opb) && $stable(result)) else $error("test altered data");
  a_branch_miss: assert property (launch && cn.op == cond_branch_op && !cond_hit
    |=> $stable(instr_pointer)) else $error("untaken branch moved pointer");
  a_jump_nopush: assert property (launch && cn.op == uncond_jump_op |=>
    $stable(stack_pointer_reg) && state == st_idle) else $error("jump touched stack");
  a_rel_target: assert property (launch && cn.op == uncond_jump_op
    && cn.kind == tgt_rel && cn.mode64 |=>
    instr_pointer == $past(instr_pointer) + $past(disp)) else $error("relative target");
  a_gate_refuse: assert property (launch && cn.op == uncond_jump_op
    && cn.kind[2] && !cn.prot |=> err && $stable(instr_pointer))
    else $error("gate accepted outside protected mode");
  a_call_push: assert property (s_call_go |=> state == st_push ##1
    state == st_idle && stack_pointer_reg == $past(stack_pointer_reg) - step
    && stack_mem[slot(stack_pointer_reg, ctrl_q.mode64)] == $past(push_a))
    else $error("call push wrong");
  a_ret_release: assert property (s_ret_go |=> state == st_pop ##1
    stack_pointer_reg == $past(stack_pointer_reg) + step + $past(imm))
    else $error("return pointer release wrong");
  a_intr_push: assert property (launch && cn.op == intr_service_op && !bad_tgt
    |=> state == st_push [*2] ##1 state == st_idle) else $error("interrupt push steps");
endmodule

// ==== ctu_host_model.sv ====
// Host model: an AXI4-Lite master standing for the software that drives the unit.
`timescale 1ns/100ps
module ctu_host_model (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       awaddr,
  output logic [2:0]       awprot,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels.
  output logic [7:0]       araddr,
  output logic [2:0]       arprot,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Every request line starts idle at time zero.
  initial begin
    {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
  end

  // One write: address and data offered together, each dropped once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit h);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 200);
    r = bresp;
    h = (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // One read: the address stands until taken, rready until the data arrives.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit h);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 200);
    d = rdata;
    r = rresp;
    h = (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
endmodule

// ==== control_transfer_unit_tb.sv ====
// Self-checking bench for the control transfer unit through its register bus.
`timescale 1ns/100ps
module control_transfer_unit_tb
  import ctu_pkg::*;
;
  // Clock, reset and the bus between host model and unit.
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  // Tallies of mismatches and comparisons.
  int          errors = 0;
  int          compares = 0;

  // Clock at 250 MHz.
  always #2 aclk = ~aclk;

  // Unit under test.
  control_transfer_unit control_transfer_unit_i (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );
  // Bus master that stands for software.
  ctu_host_model ctu_host_model_i (
    .aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );

  // Print the verdict and stop.
  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value and report a mismatch at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A bus wait that ran out ends the run as a failure.
  task automatic hang_check(input bit h);
    if (h) begin
      errors++;
      give_verdict();
    end
  endtask

  // Register write with a check of the response code.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    logic [1:0] r;
    bit         h;
    ctu_host_model_i.wr(a, d, r, h);
    hang_check(h);
    cmp({30'h0, r}, {30'h0, e});
  endtask

  // Register read compared with an expected word and response code.
  task automatic chk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = RESP_OK);
    logic [31:0] d;
    logic [1:0]  r;
    bit          h;
    ctu_host_model_i.rd(a, d, r, h);
    hang_check(h);
    cmp(d, x);
    cmp({30'h0, r}, {30'h0, e});
  endtask

  // Build a command word.
  function automatic logic [31:0] cmd(op_e o, tgt_e k = tgt_rel, logic [3:0] c = 4'h0,
                                      logic m = 1'b0, logic p = 1'b0);
    ctrl_s s;
    s = '0;
    s.op = o;
    s.kind = k;
    s.cond = c;
    s.mode64 = m;
    s.prot = p;
    return s;
  endfunction

  // Launch a command and poll until the busy bit drops.
  task automatic run(input logic [31:0] c);
    logic [31:0] s;
    logic [1:0]  r;
    bit          h;
    int          n;
    wreg(A_CTRL, c);
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 20) begin
      ctu_host_model_i.rd(A_STAT, s, r, h);
      hang_check(h);
      n++;
    end
    hang_check(n >= 20);
  endtask

  // Main sequence: reset, register defaults, then one scenario after another.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(A_FLG, FLAGS_RST);
    chk(A_IPL, IP_RST[31:0]);
    chk(A_SP, SP_RST);
    chk(A_STAT, 32'h0);
    chk(8'h30, 32'h0, RESP_ERR);
    wreg(8'h30, 32'h1, RESP_ERR);
    // Overflow byte set, plain and inverted, with the flag set and clear.
    for (int i = 0; i < 4; i++) begin
      wreg(A_FLG, FLAGS_RST | (32'(i[0]) << FLG_O));
      run(cmd(cond_byte_set_op, tgt_rel, CC_OVERFLOW | 4'(i[1])));
      chk(A_RES, (i[0] ^ i[1]) ? 32'(BYTE_ONE) : 32'(BYTE_ZERO));
    end
    // Every condition group with carry and sign set, zero, parity and overflow clear.
    wreg(A_FLG, FLAGS_RST | 32'h81);
    for (int c = 0; c < 8; c++) begin
      run(cmd(cond_byte_set_op, tgt_rel, 4'(c << 1)));
      chk(A_RES, 32'(8'hda >> c) & 32'h1);
    end
    // Test with a negative result, then with a zero result.
    wreg(A_FLG, FLAGS_RST | 32'h40);
    wreg(A_OPA, 32'h8000_00ff);
    wreg(A_OPB, 32'h8000_0003);
    run(cmd(bit_test_op));
    chk(A_FLG, FLAGS_RST | 32'h84);
    chk(A_OPA, 32'h8000_00ff);
    chk(A_OPB, 32'h8000_0003);
    wreg(A_OPA, 32'hf0);
    wreg(A_OPB, 32'h0f);
    run(cmd(bit_test_op));
    chk(A_FLG, FLAGS_RST | 32'h44);
    // Backward relative jump, then register, far and near memory targets.
    wreg(A_IPL, 32'h100);
    wreg(A_SP, 32'h80);
    wreg(A_CS, 32'h11);
    wreg(A_OPB, 32'hffff_fff0);
    run(cmd(uncond_jump_op));
    chk(A_IPL, 32'hf0);
    chk(A_SP, 32'h80);
    wreg(A_OPB, 32'h2000);
    run(cmd(uncond_jump_op, tgt_reg));
    chk(A_IPL, 32'h2000);
    chk(A_CS, 32'h11);
    wreg(A_SEL, 32'h33);
    wreg(A_OPB, 32'h4000);
    run(cmd(uncond_jump_op, tgt_far));
    chk(A_CS, 32'h33);
    chk(A_IPL, 32'h4000);
    wreg(A_SEL, 32'h55);
    wreg(A_OPB, 32'h2400);
    run(cmd(uncond_jump_op, tgt_near));
    chk(A_CS, 32'h33);
    chk(A_IPL, 32'h2400);
    // Gate and task targets in protected mode, then a tgt_cgate jump refused outside it.
    for (int k = 4; k < 7; k++) begin
      wreg(A_SEL, 32'h40 + k);
      wreg(A_OPB, 32'h5000 + k);
      run(cmd(uncond_jump_op, tgt_e'(k), 4'h0, 1'b0, 1'b1));
      chk(A_CS, 32'h40 + k);
      chk(A_IPL, 32'h5000 + k);
      chk(A_STAT, 32'h4);
    end
    wreg(A_OPB, 32'h6000);
    run(cmd(uncond_jump_op, tgt_cgate));
    chk(A_STAT, 32'h2);
    chk(A_IPL, 32'h5006);
    // A call through a gate and the invalid kind are refused even in protected mode.
    run(cmd(proc_call_op, tgt_tgate, 4'h0, 1'b0, 1'b1));
    chk(A_STAT, 32'h2);
    chk(A_IPL, 32'h5006);
    chk(A_SP, 32'h80);
    run(cmd(uncond_jump_op, tgt_rsv, 4'h0, 1'b0, 1'b1));
    chk(A_STAT, 32'h2);
    // Nested calls and returns, the last one releasing eight bytes.
    wreg(A_IPL, 32'h1000);
    wreg(A_SP, 32'h40);
    wreg(A_IMM, 32'h0);
    wreg(A_OPB, 32'h3000);
    run(cmd(proc_call_op, tgt_near));
    chk(A_IPL, 32'h3000);
    chk(A_SP, 32'h3c);
    wreg(A_OPB, 32'h10);
    run(cmd(proc_call_op));
    chk(A_IPL, 32'h3010);
    run(cmd(proc_return_op));
    chk(A_IPL, 32'h3000);
    chk(A_SP, 32'h3c);
    wreg(A_IMM, 32'h8);
    run(cmd(proc_return_op));
    chk(A_IPL, 32'h1000);
    chk(A_SP, 32'h48);
    // Interrupt entry saves flags and pointer; interrupt return restores both.
    wreg(A_IMM, 32'h0);
    wreg(A_FLG, FLAGS_RST | 32'h800);
    wreg(A_IPL, 32'h500);
    wreg(A_OPB, 32'h6000);
    run(cmd(intr_service_op, tgt_near));
    chk(A_IPL, 32'h6000);
    chk(A_SP, 32'h40);
    wreg(A_FLG, FLAGS_RST);
    run(cmd(intr_return_op));
    chk(A_IPL, 32'h500);
    chk(A_FLG, FLAGS_RST | 32'h800);
    chk(A_SP, 32'h48);
    // Branch on zero: not taken, taken, then inverted and not taken.
    wreg(A_FLG, FLAGS_RST);
    wreg(A_IPL, 32'h700);
    wreg(A_OPB, 32'h20);
    run(cmd(cond_branch_op, tgt_rel, 4'h4));
    chk(A_IPL, 32'h700);
    wreg(A_FLG, FLAGS_RST | 32'h40);
    run(cmd(cond_branch_op, tgt_rel, 4'h4));
    chk(A_IPL, 32'h720);
    run(cmd(cond_branch_op, tgt_rel, 4'h5));
    chk(A_IPL, 32'h720);
    // Wide mode call, return and jump with eight-byte slots, then a narrow jump.
    wreg(A_SP, 32'h80);
    wreg(A_IPH, 32'h1);
    wreg(A_IPL, 32'h20);
    wreg(A_OPB, 32'h10);
    run(cmd(proc_call_op, tgt_rel, 4'h0, 1'b1));
    chk(A_IPL, 32'h30);
    chk(A_IPH, 32'h1);
    chk(A_SP, 32'h78);
    run(cmd(proc_return_op, tgt_rel, 4'h0, 1'b1));
    chk(A_IPL, 32'h20);
    chk(A_SP, 32'h80);
    chk(A_IPH, 32'h1);
    run(cmd(uncond_jump_op, tgt_rel, 4'h0, 1'b1));
    chk(A_IPL, 32'h30);
    chk(A_IPH, 32'h1);
    run(cmd(uncond_jump_op));
    chk(A_IPH, 32'h0);
    chk(A_IPL, 32'h40);
    give_verdict();
  end
endmodule
